// ---- vector_priority_pkg.sv ----
// package: register map, field positions and vector constants
package vector_priority_pkg;

  // ****************************************************************
  // register offsets (word index, byte address is four times)
  // ****************************************************************
  localparam logic [7:0] test_control_idx  = 8'h15;
  localparam logic [7:0] test_force_idx    = 8'h16;
  localparam logic [7:0] promotion_idx     = 8'h1f;
  localparam logic [7:0] wake_status_idx   = 8'h20;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int         override_bit      = 4;
  localparam logic [3:0] select_reset      = 4'h0;
  localparam logic [7:0] promotion_reset   = 8'hf2;
  localparam logic [7:0] top_maskable_low  = 8'hf2;
  localparam logic [7:0] secondary_low     = 8'hf4;

  // ****************************************************************
  // exception vector addresses
  // ****************************************************************
  localparam logic [15:0] vec_base         = 16'hff00;
  localparam logic [15:0] vec_system_reset = 16'hfffe;
  localparam logic [15:0] vec_clock_reset  = 16'hfffc;
  localparam logic [15:0] vec_watchdog     = 16'hfffa;
  localparam logic [15:0] vec_trap         = 16'hfff8;
  localparam logic [15:0] vec_software     = 16'hfff6;
  localparam logic [15:0] vec_secondary    = 16'hfff4;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic system_reset;
    logic clock_monitor_reset;
    logic watchdog_reset;
    logic trap;
    logic software_interrupt;
  } fixed_req_t;

  typedef struct packed {
    logic special_mode;
    logic i_mask;
    logic x_mask;
  } cpu_state_t;

endpackage

// ---- exception_vector_priority_unit.sv ----
// exception priority decoder with test registers and promotion select
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module exception_vector_priority_unit
  import vector_priority_pkg::*;
#(
  parameter int num_vectors = 122
)(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   clk_en,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic [num_vectors-1:0] irq_lines,
  input  wire logic                   secondary_request_pin,
  input  wire fixed_req_t             fixed_req,
  input  wire cpu_state_t             cpu_condition_flags,
  input  wire logic                   inhibit_maskable,
  input  wire logic                   inhibit_secondary,
  input  wire logic                   vector_request,
  output logic                        int_pending,
  output logic      [15:0]            vector_addr,
  output logic                        wake_up
);

  localparam int nregs = (num_vectors + 1 + 7) / 8;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // index 0..num_vectors-1 maskable (0xff00 + 2i), num_vectors secondary
  logic [num_vectors:0] raw_in;
  logic [num_vectors:0] sync1_reg;
  logic [num_vectors:0] sync2_reg;

  // the secondary pin is active low; the decoder index is active high
  assign raw_in = {~secondary_request_pin, irq_lines};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  logic       ap_wr_reg;
  logic       ap_rd_reg;
  logic [7:0] ap_idx_reg;
  logic       access_ok;

  assign access_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg  <= 1'b0;
      ap_rd_reg  <= 1'b0;
      ap_idx_reg <= 8'h00;
    end else if (clk_en) begin
      ap_wr_reg  <= access_ok && hwrite;
      ap_rd_reg  <= access_ok && !hwrite;
      if (access_ok) begin
        ap_idx_reg <= haddr[9:2];
      end
    end
  end

  // ****************************************************************
  // test control, promotion select and test registers
  // ****************************************************************
  logic              override_reg;
  logic [3:0]        select_reg;
  logic [7:0]        promotion_reg;
  logic [7:0]        force_reg [nregs];
  logic [7:0]        wdata;
  logic              special;
  logic              wr_ctrl;
  logic              wr_force;
  logic              wr_prom;

  assign wdata    = hwdata[7:0];
  assign special  = cpu_condition_flags.special_mode;
  assign wr_ctrl  = ap_wr_reg && ap_idx_reg == test_control_idx;
  assign wr_force = ap_wr_reg && ap_idx_reg == test_force_idx && special
                    && override_reg && cpu_condition_flags.i_mask;
  assign wr_prom  = ap_wr_reg && ap_idx_reg == promotion_idx
                    && cpu_condition_flags.i_mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      select_reg   <= select_reset;
      override_reg <= 1'b0;
    end else if (clk_en && wr_ctrl) begin
      select_reg <= wdata[3:0];
      if (special && cpu_condition_flags.i_mask
          && cpu_condition_flags.x_mask) begin
        override_reg <= wdata[override_bit];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      promotion_reg <= promotion_reset;
    end else if (clk_en && wr_prom) begin
      promotion_reg <= {wdata[7:1], 1'b0};
    end
  end

  // live view of inputs padded to whole test registers
  logic [nregs*8-1:0] live_vec;
  logic [nregs*8-1:0] forced_vec;
  logic               set_override;

  assign live_vec     = (nregs*8)'(sync2_reg);
  assign set_override = wr_ctrl && wdata[override_bit] && !override_reg
                        && special && cpu_condition_flags.i_mask
                        && cpu_condition_flags.x_mask;

  genvar g;
  generate
    for (g = 0; g < nregs; g++) begin : g_force
      // bits above the secondary vector cannot be forced
      localparam int nbits = (g*8 + 8 > num_vectors + 1) ?
                             num_vectors + 1 - g*8 : 8;
      localparam logic [7:0] bmask = 8'((9'h1 << nbits) - 9'h1);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          force_reg[g] <= 8'h00;
        end else if (clk_en) begin
          if (set_override) begin
            force_reg[g] <= live_vec[g*8 +: 8];
          end else if (wr_force && select_reg == 4'(g)) begin
            force_reg[g] <= wdata & bmask;
          end
        end
      end
      assign forced_vec[g*8 +: 8] = force_reg[g];
    end
  endgenerate

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [7:0] test_rd;
  logic [7:0] rd_byte;

  always_comb begin
    test_rd = 8'h00;
    if (special && int'(select_reg) < nregs) begin
      test_rd = override_reg ? forced_vec[select_reg*8 +: 8]
                             : live_vec[select_reg*8 +: 8];
    end
  end

  always_comb begin
    unique case (ap_idx_reg)
      test_control_idx: rd_byte = {3'h0, override_reg, select_reg};
      test_force_idx:   rd_byte = test_rd;
      promotion_idx:    rd_byte = promotion_reg;
      wake_status_idx:  rd_byte = {6'h00, wake_up, int_pending};
      default:          rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      // one wait state on reads so registered data stands when taken
      hreadyout <= !(access_ok && !hwrite);
      hresp     <= 1'b0;
      if (ap_rd_reg) begin
        hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ****************************************************************
  // priority decoder
  // ****************************************************************
  logic [num_vectors:0] req_src;
  logic [num_vectors:0] req_valid;
  logic                 prom_hit;
  logic [15:0]          best_vec;
  logic                 any_req;
  logic [7:0]           prom_eff;

  assign req_src = override_reg ? forced_vec[num_vectors:0]
                                : sync2_reg;

  always_comb begin
    req_valid = req_src;
    if (inhibit_maskable || cpu_condition_flags.i_mask) begin
      req_valid[num_vectors-1:0] = '0;
    end
    if (inhibit_secondary || cpu_condition_flags.x_mask) begin
      req_valid[num_vectors] = 1'b0;
    end
  end

  // promoted byte above the top maskable vector (0xf2) falls back to the top maskable vector
  assign prom_eff = (promotion_reg > top_maskable_low) ?
                    top_maskable_low : promotion_reg;
  assign prom_hit = int'(prom_eff[7:1]) < num_vectors
                    && req_valid[prom_eff[7:1]];

  always_comb begin
    best_vec = 16'h0000;
    any_req  = 1'b1;
    if (fixed_req.system_reset) begin
      best_vec = vec_system_reset;
    end else if (fixed_req.clock_monitor_reset) begin
      best_vec = vec_clock_reset;
    end else if (fixed_req.watchdog_reset) begin
      best_vec = vec_watchdog;
    end else if (fixed_req.trap) begin
      best_vec = vec_trap;
    end else if (fixed_req.software_interrupt) begin
      best_vec = vec_software;
    end else if (req_valid[num_vectors]) begin
      best_vec = vec_secondary;
    end else if (prom_hit) begin
      best_vec = {8'hff, prom_eff};
    end else begin
      any_req = 1'b0;
      for (int i = 0; i < num_vectors; i++) begin
        if (req_valid[i]) begin
          best_vec = vec_base + 16'(2*i);
          any_req  = 1'b1;
        end
      end
    end
  end

  logic [15:0] last_vec_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_vec_reg <= vec_software;
      int_pending  <= 1'b0;
      vector_addr  <= vec_software;
    end else if (clk_en) begin
      int_pending <= any_req;
      if (any_req) begin
        last_vec_reg <= best_vec;
      end
      if (vector_request) begin
        vector_addr <= any_req ? best_vec : last_vec_reg;
      end
    end
  end

  // ****************************************************************
  // wake-up: clockless combine, registered copy for the output port
  // ****************************************************************
  logic wake_async;

  assign wake_async = !secondary_request_pin
                      || (|irq_lines && !cpu_condition_flags.i_mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= wake_async;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  fetch_vector_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && vector_request && any_req |=> vector_addr == $past(best_vec))
    else $error("vector fetch gave wrong vector");
  reset_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && vector_request && fixed_req.system_reset
    |=> vector_addr == vec_system_reset)
    else $error("system reset not top priority");
  no_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && vector_request && !any_req
    |=> vector_addr == $past(last_vec_reg))
    else $error("vanished source vector wrong");
  inhibit_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    inhibit_maskable |-> req_valid[num_vectors-1:0] == '0)
    else $error("inhibited request reached decoder");
  override_guard_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !special && !override_reg |=> !override_reg)
    else $error("override set outside special mode");
  force_guard_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !override_reg && clk_en |=> $stable(forced_vec) || $past(set_override))
    else $error("test register written with override clear");
  normal_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !special |-> test_rd == 8'h00)
    else $error("test read nonzero in normal mode");
  top_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !special || !override_reg || select_reg != 4'hf
    || int'(select_reg) >= nregs || test_rd[7:3] == 5'h00)
    else $error("high bits visible in last test register");
  wake_sec_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !secondary_request_pin |=> wake_up)
    else $error("secondary pin did not wake");

  fetch_c:    cover property (@(posedge hclk) vector_request && any_req);
  override_c: cover property (@(posedge hclk) set_override);
  force_c:    cover property (@(posedge hclk) wr_force);
  promote_c:  cover property (@(posedge hclk) prom_hit && vector_request);

endmodule

// ---- cpu_core_model.sv ----
// cpu core model: condition flags and the vector fetch handshake
`timescale 1ns/1ns
module cpu_core_model
  import vector_priority_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic [15:0] vector_addr,
  output logic             vector_request,
  output cpu_state_t       cpu_condition_flags
);
  initial begin
    vector_request      = 1'b0;
    cpu_condition_flags = '0;
  end

  // ****************************************************************
  // core side tasks
  // ****************************************************************
  // mode and mask bits as the core presents them
  task automatic set_flags(input logic sp, input logic im, input logic xm);
    @(posedge hclk);
    cpu_condition_flags <= '{sp, im, xm};
  endtask

  // request held one cycle; vector sampled once the taking edge settled
  task automatic fetch(output logic [15:0] v);
    @(posedge hclk);
    vector_request <= 1'b1;
    @(posedge hclk);
    vector_request <= 1'b0;
    #1 v = vector_addr;
  endtask
endmodule

// ---- exception_vector_priority_unit_tb.sv ----
// testbench: registers, priority, test registers and wake-up
`timescale 1ns/1ns
`define CHK(g, e) check(32'(g), 32'(e))
module exception_vector_priority_unit_tb;
  import vector_priority_pkg::*;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         clk_en = 1'b1;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [2:0]   hsize = 3'h2;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic [121:0] irq_lines = '0;
  logic         secondary_pin_n = 1'b1;
  fixed_req_t   fixed_req = '0;
  cpu_state_t   flags;
  logic         inh_m = 1'b0;
  logic         inh_s = 1'b0;
  logic         vreq;
  logic         int_pending;
  logic [15:0]  vector_addr;
  logic         wake_up;
  logic [7:0]   rv;
  logic [15:0]  vv;
  int           err_count = 0;
  int           n_checks = 0;

  always #10 hclk = ~hclk;

  exception_vector_priority_unit #(.num_vectors(122)) DUT (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_lines(irq_lines),
    .secondary_request_pin(secondary_pin_n), .fixed_req(fixed_req),
    .cpu_condition_flags(flags), .inhibit_maskable(inh_m),
    .inhibit_secondary(inh_s), .vector_request(vreq),
    .int_pending(int_pending), .vector_addr(vector_addr),
    .wake_up(wake_up)
  );

  cpu_core_model cpu (
    .hclk(hclk), .vector_addr(vector_addr), .vector_request(vreq),
    .cpu_condition_flags(flags)
  );

  // ****************************************************************
  // common tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic timeout;
    err_count++;
    $display("MISMATCH t=%0t wait ran out", $time);
    results();
  endtask

  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) timeout();
  endtask

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    haddr  <= {22'h0, idx, 2'b00};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    q = hrdata[7:0];
    `CHK(hresp, 1'b0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rv);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    bus(1'b0, idx, 8'h00, q);
  endtask

  // inputs cross two sync flops before the decoder sees them
  task automatic settle;
    repeat (4) @(posedge hclk);
  endtask

  task automatic await(input logic w, input logic lvl);
    int k;
    for (k = 0; k < 20 && (w ? wake_up : int_pending) !== lvl; k++) begin
      @(posedge hclk);
    end
    if ((w ? wake_up : int_pending) !== lvl) timeout();
  endtask

  task automatic fetch_is(input logic [15:0] e);
    cpu.fetch(vv);
    `CHK(vv, e);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    `CHK(vector_addr, vec_software);
    `CHK(int_pending, 1'b0);
    rd(test_control_idx, rv);
    `CHK(rv, 8'h00);
    rd(promotion_idx, rv);
    `CHK(rv, promotion_reset);
    rd(8'h10, rv);
    `CHK(rv, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_fixed;
    cpu.set_flags(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      fixed_req <= fixed_req_t'(5'h1f >> i);
      settle();
      fetch_is(16'(vec_system_reset - 2 * i));
    end
    fixed_req <= '0;
    settle();
    fetch_is(vec_software);
    $display("test fixed done");
  endtask

  task automatic t_mask;
    irq_lines[0] <= 1'b1;
    await(1'b0, 1'b1);
    fetch_is(vec_base);
    irq_lines[121] <= 1'b1;
    settle();
    fetch_is(16'hfff2);
    inh_m <= 1'b1;
    settle();
    `CHK(int_pending, 1'b0);
    fetch_is(16'hfff2);
    inh_m <= 1'b0;
    cpu.set_flags(1'b0, 1'b1, 1'b1);
    settle();
    `CHK(int_pending, 1'b0);
    irq_lines <= '0;
    $display("test mask done");
  endtask

  task automatic t_promo;
    wr(promotion_idx, 8'h10);
    rd(promotion_idx, rv);
    `CHK(rv, 8'h10);
    cpu.set_flags(1'b0, 1'b0, 1'b1);
    wr(promotion_idx, 8'h20);
    rd(promotion_idx, rv);
    `CHK(rv, 8'h10);
    irq_lines[8] <= 1'b1;
    irq_lines[121] <= 1'b1;
    settle();
    fetch_is(16'hff10);
    cpu.set_flags(1'b0, 1'b1, 1'b1);
    wr(promotion_idx, 8'hf4);
    cpu.set_flags(1'b0, 1'b0, 1'b1);
    settle();
    fetch_is(16'hfff2);
    irq_lines <= '0;
    $display("test promo done");
  endtask

  task automatic t_test;
    irq_lines[0] <= 1'b1;
    rd(test_force_idx, rv);
    `CHK(rv, 8'h00);
    cpu.set_flags(1'b1, 1'b0, 1'b1);
    wr(test_control_idx, 8'h17);
    rd(test_control_idx, rv);
    `CHK(rv, 8'h07);
    wr(test_control_idx, 8'h00);
    wr(test_force_idx, 8'hff);
    rd(test_force_idx, rv);
    `CHK(rv, 8'h01);
    cpu.set_flags(1'b1, 1'b1, 1'b1);
    wr(test_control_idx, 8'h10);
    irq_lines <= '0;
    settle();
    rd(test_force_idx, rv);
    `CHK(rv, 8'h01);
    wr(test_control_idx, 8'h17);
    wr(test_force_idx, 8'h05);
    rd(test_force_idx, rv);
    `CHK(rv, 8'h05);
    cpu.set_flags(1'b1, 1'b0, 1'b1);
    wr(test_force_idx, 8'h80);
    rd(test_force_idx, rv);
    `CHK(rv, 8'h05);
    settle();
    fetch_is(16'hff74);
    cpu.set_flags(1'b1, 1'b1, 1'b1);
    wr(test_control_idx, 8'h10);
    rd(test_force_idx, rv);
    `CHK(rv, 8'h01);
    wr(test_control_idx, 8'h1f);
    wr(test_force_idx, 8'hff);
    rd(test_force_idx, rv);
    `CHK(rv, 8'h07);
    wr(test_force_idx, 8'h00);
    wr(test_control_idx, 8'h00);
    $display("test force done");
  endtask

  task automatic t_wake;
    cpu.set_flags(1'b0, 1'b1, 1'b1);
    secondary_pin_n <= 1'b0;
    await(1'b1, 1'b1);
    rd(wake_status_idx, rv);
    `CHK(rv[1], 1'b1);
    cpu.set_flags(1'b0, 1'b1, 1'b0);
    settle();
    fetch_is(vec_secondary);
    inh_s <= 1'b1;
    settle();
    `CHK(int_pending, 1'b0);
    inh_s <= 1'b0;
    cpu.set_flags(1'b0, 1'b1, 1'b1);
    secondary_pin_n <= 1'b1;
    await(1'b1, 1'b0);
    irq_lines[3] <= 1'b1;
    cpu.set_flags(1'b0, 1'b0, 1'b1);
    await(1'b1, 1'b1);
    `CHK(wake_up, 1'b1);
    irq_lines <= '0;
    $display("test wake done");
  endtask

  // clock enable low freezes the request path
  task automatic t_freeze;
    settle();
    clk_en <= 1'b0;
    irq_lines[5] <= 1'b1;
    settle();
    `CHK(int_pending, 1'b0);
    clk_en <= 1'b1;
    await(1'b0, 1'b1);
    fetch_is(16'hff0a);
    irq_lines <= '0;
    $display("test freeze done");
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_fixed();
    t_mask();
    t_promo();
    t_test();
    t_wake();
    t_freeze();
    results();
  end
endmodule
